//--- hw/adc_trim_and_sequence_ctrl.sv
// Function
// - Attenuation code selects bypass or x2/x3/x4 scaling.
// - Mute ties converter input to half reference.
// - Sign bit inverts comparator offset polarity.
// - Chopper alternates offset sign per conversion.
// - Non-zero average exponent averages multiple conversions.
// - Bias load enable turns on 20 uA load.
// - Trims drive offset network; 0x200 means none.
// - Equal trims shift differential common-mode level.
// - Single-ended select chooses sampling mode.
// - An irq clear write clears pending interrupt unless a result finishes in the same cycle.
// - Start stays high while busy; ignored restart.
// - Average two-power samples, 16-bit left aligned.
// - Chopper takes opposite-sign conversion pairs.
`timescale 1ns/10ps
`default_nettype none
module adc_trim_and_sequence_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_CYCLES = 4
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic converter_enable_in,
    input wire logic conversion_start_wr_in,
    input wire logic continuous_sel_in,
    input wire logic single_ended_sel_in,
    input wire logic [CHAN_W-1:0] channel_select_in,
    input wire logic [ATTN_W-1:0] input_attenuation_sel_in,
    input wire logic input_mute_in,
    input wire logic offset_sign_invert_in,
    input wire logic chopper_enable_in,
    input wire logic [AVG_W-1:0] average_count_exp_in,
    input wire logic [SMPL_W-1:0] sample_time_sel_in,
    input wire logic regulator_bias_load_en_in,
    input wire logic [TRIM_W-1:0] pos_offset_trim_in,
    input wire logic [TRIM_W-1:0] neg_offset_trim_in,
    input wire logic irq_clear_port_wr_in,
    input wire logic [RAW_W-1:0] raw_sample_in,
    output logic conversion_start_out,
    output logic conversion_done_irq_out,
    output logic [RESULT_W-1:0] result_value_out,
    output logic [ATTN_W-1:0] analog_attn_out,
    output logic analog_attn_bypass_out,
    output logic analog_mute_out,
    output logic analog_sign_out,
    output logic analog_single_ended_out,
    output logic [CHAN_W-1:0] analog_channel_out,
    output logic analog_bias_load_out,
    output logic [TRIM_W-1:0] analog_pos_trim_out,
    output logic [TRIM_W-1:0] analog_neg_trim_out,
    output logic analog_sample_out
);

    // ==========================================================
    // Sequencer
    seq_state_type state_q, state_d;
    logic [7:0] cnt_q;
    logic [8:0] conv_left_q;
    logic [ACC_W-1:0] acc_q;
    logic [AVG_W-1:0] exp_q;
    logic chop_q;
    logic sign_q;

    wire idle = (state_q == ST_IDLE);
    wire go = idle && converter_enable_in && conversion_start_wr_in;
    wire [8:0] pow_n = 9'h001 << average_count_exp_in;
    // Chopping needs at least a pair so the offset cancels.
    wire [8:0] n_conv = (chopper_enable_in && pow_n < 9'h002) ? 9'h002 : pow_n;
    wire [7:0] smpl_len = 8'(SMPL_CYCLES_PER_STEP) * {4'h0, sample_time_sel_in};
    wire cnt_done = (cnt_q == 8'h00);
    wire last_conv = (conv_left_q == 9'h001);
    wire [ACC_W-1:0] acc_sum = acc_q + {{(ACC_W-RAW_W){1'b0}}, raw_sample_in};
    // Chopper pairs: effective exponent is at least one.
    wire [AVG_W-1:0] eff_exp = (chop_q && exp_q == 3'h0) ? 3'h1 : exp_q;
    wire [ACC_W-1:0] avg_val = acc_sum >> eff_exp;
    // The fraction bits of the mean fill the low bits, so averaging gains resolution.
    wire [ACC_W-1:0] avg_fine = (acc_sum << (RESULT_W - RAW_W)) >> eff_exp;
    wire [RESULT_W-1:0] left_al = avg_fine[RESULT_W-1:0];
    wire sign_next = chop_q ? ~sign_q : sign_q;
    // The pin must show the sign of the sample about to start, not of the one just stored.
    wire sign_d = (idle || (state_q == ST_STORE && last_conv)) ? offset_sign_invert_in
        : ((state_q == ST_STORE) ? sign_next : sign_q);
    wire restart = continuous_sel_in && converter_enable_in;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (go) state_d = ST_SAMPLE;
            ST_SAMPLE: if (cnt_done) state_d = ST_CONVERT;
            ST_CONVERT: if (cnt_done) state_d = ST_STORE;
            ST_STORE: begin
                if (!last_conv) state_d = ST_SAMPLE;
                else if (restart) state_d = ST_SAMPLE;
                else state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            cnt_q <= 8'h00;
            conv_left_q <= 9'h000;
            acc_q <= '0;
            exp_q <= 3'h0;
            chop_q <= 1'b0;
            sign_q <= 1'b0;
        end else if (clk_en_in) begin
            state_q <= state_d;
            if (idle || (state_q == ST_STORE && last_conv)) begin
                conv_left_q <= n_conv;
                exp_q <= average_count_exp_in;
                chop_q <= chopper_enable_in;
                sign_q <= offset_sign_invert_in;
                acc_q <= '0;
                cnt_q <= smpl_len;
            end else if (state_q == ST_STORE) begin
                conv_left_q <= conv_left_q - 9'h001;
                acc_q <= acc_sum;
                sign_q <= sign_next;
                cnt_q <= smpl_len;
            end else if (cnt_done) begin
                cnt_q <= 8'(CONV_CYCLES - 1);
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

    // ==========================================================
    // Status and result
    wire finish = (state_q == ST_STORE) && last_conv;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            conversion_start_out <= 1'b0;
            conversion_done_irq_out <= 1'b0;
            result_value_out <= '0;
        end else if (clk_en_in) begin
            // Writes while busy fall through: start already reads one.
            if (go) conversion_start_out <= 1'b1;
            else if (finish && !restart) conversion_start_out <= 1'b0;
            // Set beats a clear landing in the same cycle.
            if (finish) conversion_done_irq_out <= 1'b1;
            else if (irq_clear_port_wr_in) conversion_done_irq_out <= 1'b0;
            if (finish) result_value_out <= left_al;
        end
    end

    // ==========================================================
    // Analog controls
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            analog_attn_out <= ATTN_BYPASS;
            analog_attn_bypass_out <= 1'b1;
            analog_mute_out <= 1'b0;
            analog_sign_out <= 1'b0;
            analog_single_ended_out <= 1'b0;
            analog_channel_out <= '0;
            analog_bias_load_out <= 1'b0;
            analog_pos_trim_out <= TRIM_MID;
            analog_neg_trim_out <= TRIM_MID;
            analog_sample_out <= 1'b0;
        end else if (clk_en_in) begin
            analog_attn_out <= input_attenuation_sel_in;
            analog_attn_bypass_out <= (input_attenuation_sel_in == ATTN_BYPASS);
            analog_mute_out <= input_mute_in;
            analog_sign_out <= sign_d;
            analog_single_ended_out <= single_ended_sel_in;
            analog_channel_out <= channel_select_in;
            analog_bias_load_out <= regulator_bias_load_en_in;
            analog_pos_trim_out <= pos_offset_trim_in;
            analog_neg_trim_out <= neg_offset_trim_in;
            analog_sample_out <= (state_d == ST_SAMPLE);
        end
    end

    // ==========================================================
    // Checks
    property p_irq_hold;
        @(posedge mclk_in) disable iff (rst_in)
        conversion_done_irq_out && !irq_clear_port_wr_in |=> conversion_done_irq_out;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear");

    property p_irq_clear;
        @(posedge mclk_in) disable iff (rst_in)
        clk_en_in && irq_clear_port_wr_in && !finish |=> !conversion_done_irq_out;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("clear write ignored");

    property p_finish_sets;
        @(posedge mclk_in) disable iff (rst_in)
        clk_en_in && finish |=> conversion_done_irq_out
            && result_value_out[RESULT_W-1:RESULT_W-RAW_W] == $past(avg_val[RAW_W-1:0]);
    endproperty
    a_finish_sets: assert property (p_finish_sets) else $error("finish did not flag");

    property p_busy_start;
        @(posedge mclk_in) disable iff (rst_in)
        !idle |-> conversion_start_out;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("start low while busy");

    property p_chop_toggle;
        @(posedge mclk_in) disable iff (rst_in)
        clk_en_in && state_q == ST_STORE && !last_conv && chop_q |=> sign_q != $past(sign_q);
    endproperty
    a_chop_toggle: assert property (p_chop_toggle) else $error("chopper sign not flipped");

    property p_chop_pair;
        @(posedge mclk_in) disable iff (rst_in)
        clk_en_in && go && chopper_enable_in |=> conv_left_q >= 9'h002;
    endproperty
    a_chop_pair: assert property (p_chop_pair) else $error("chopper without pair");

    property p_avg_count;
        @(posedge mclk_in) disable iff (rst_in)
        clk_en_in && go && !chopper_enable_in |=> conv_left_q == $past(pow_n);
    endproperty
    a_avg_count: assert property (p_avg_count) else $error("wrong average count");

    property p_attn;
        @(posedge mclk_in) disable iff (rst_in)
        clk_en_in |=> analog_attn_bypass_out == ($past(input_attenuation_sel_in) == ATTN_BYPASS);
    endproperty
    a_attn: assert property (p_attn) else $error("attenuator bypass wrong");

    property p_mute_bias;
        @(posedge mclk_in) disable iff (rst_in)
        clk_en_in |=> analog_mute_out == $past(input_mute_in)
            && analog_bias_load_out == $past(regulator_bias_load_en_in);
    endproperty
    a_mute_bias: assert property (p_mute_bias) else $error("mute or bias load wrong");

endmodule
`default_nettype wire

//--- hw/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    localparam int ATTN_W = 2;
    localparam logic [1:0] ATTN_BYPASS = 2'h0;
    localparam int TRIM_W = 10;
    localparam logic [9:0] TRIM_MID = 10'h200;
    localparam int RAW_W = 10;
    localparam int RESULT_W = 16;
    localparam int AVG_W = 3;
    localparam int SMPL_W = 4;
    localparam int CHAN_W = 3;
    localparam int SMPL_CYCLES_PER_STEP = 8;
    localparam int ACC_W = RESULT_W + 8;
    localparam int BIAS_LOAD_UA = 20;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_STORE = 2'b11
    } seq_state_type;
endpackage

//--- sim/tb_adc_trim_and_sequence_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_adc_trim_and_sequence_ctrl;
    import adc_ctrl_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic mclk_in = 1'b0, rst_in = 1'b1, en = 1'b0, start_wr = 1'b0, cont = 1'b0, se = 1'b0;
    logic mute = 1'b0, sign = 1'b0, chop = 1'b0, bias = 1'b0, clr = 1'b0, prev_smp = 1'b0;
    logic [CHAN_W-1:0] chan = '0;
    logic [ATTN_W-1:0] attn = '0;
    logic [AVG_W-1:0] avg = '0;
    logic [SMPL_W-1:0] smpl = 4'h1;
    logic [TRIM_W-1:0] trim = TRIM_MID;
    logic [TRIM_W-1:0] ntrim = TRIM_MID;
    logic [RAW_W-1:0] res_p = '0;
    logic [RAW_W-1:0] res_n = '0;
    logic ce = 1'b1;
    logic [RAW_W-1:0] raw = '0;
    logic start_o, irq_o, bypass_o, mute_o, sign_o, se_o, bias_o, smp_o;
    logic [RESULT_W-1:0] result_o;
    logic [ATTN_W-1:0] attn_o;
    logic [CHAN_W-1:0] chan_o;
    logic [TRIM_W-1:0] ptrim_o, ntrim_o;
    logic [7:0] sign_hist = '0;
    int fails = 0, total_checks = 0, n_smp = 0;
    always #25 mclk_in = ~mclk_in;
    // Applied sign is logged at the start of each sampling phase.
    always @(posedge mclk_in) begin
        prev_smp <= smp_o;
        if (smp_o === 1'b1 && prev_smp === 1'b0) begin
            sign_hist <= {sign_hist[6:0], sign_o};
            n_smp <= n_smp + 1;
        end
    end
    adc_trim_and_sequence_ctrl dut (.mclk_in(mclk_in), .rst_in(rst_in), .clk_en_in(ce),
        .converter_enable_in(en), .conversion_start_wr_in(start_wr), .continuous_sel_in(cont),
        .single_ended_sel_in(se), .channel_select_in(chan), .input_attenuation_sel_in(attn),
        .input_mute_in(mute), .offset_sign_invert_in(sign), .chopper_enable_in(chop),
        .average_count_exp_in(avg), .sample_time_sel_in(smpl), .regulator_bias_load_en_in(bias),
        .pos_offset_trim_in(trim), .neg_offset_trim_in(ntrim), .irq_clear_port_wr_in(clr),
        .raw_sample_in(raw), .conversion_start_out(start_o), .conversion_done_irq_out(irq_o),
        .result_value_out(result_o), .analog_attn_out(attn_o), .analog_attn_bypass_out(bypass_o),
        .analog_mute_out(mute_o), .analog_sign_out(sign_o), .analog_single_ended_out(se_o),
        .analog_channel_out(chan_o), .analog_bias_load_out(bias_o), .analog_pos_trim_out(ptrim_o),
        .analog_neg_trim_out(ntrim_o), .analog_sample_out(smp_o));
    // ==========================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk_in);
            #2;
        end
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // A second start while busy must be dropped, so one is issued on purpose.
    // The raw word can step once mid-average so that the fraction bits get exercised.
    task automatic convert(input int n_conv, input logic [15:0] exp_res, input int step_at = -1,
            input logic [RAW_W-1:0] raw_step = '0);
        int k;
        int n0;
        n0 = n_smp;
        start_wr = 1'b1;
        tick(1);
        start_wr = 1'b0;
        tick(1);
        check("busy", 16'h1, {15'h0, start_o});
        start_wr = 1'b1;
        tick(1);
        start_wr = 1'b0;
        for (k = 0; k < 3000 && start_o === 1'b1; k++) begin
            if (n_smp - n0 == step_at) raw = raw_step;
            tick(1);
        end
        check("irq", 16'h1, {15'h0, irq_o});
        check("result", exp_res, result_o);
        check("samples", 16'(n_conv), 16'(n_smp - n0));
        tick(3);
        check("restart", 16'h0, {15'h0, start_o});
        check("irq held", 16'h1, {15'h0, irq_o});
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        tick(1);
        check("irq clear", 16'h0, {15'h0, irq_o});
        check("result kept", exp_res, result_o);
    endtask
    // ==========================================================
    // Tests
    initial begin
        #(50 * 40000);
        fails++;
        report_and_stop();
    end
    initial begin
        tick(10);
        check("rst trim", 16'(TRIM_MID), 16'(ptrim_o));
        check("rst trim n", 16'(TRIM_MID), 16'(ntrim_o));
        check("rst bypass", 16'h1, {15'h0, bypass_o});
        check("rst start", 16'h0, {15'h0, start_o});
        rst_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            attn = 2'(i);
            mute = i[0];
            bias = i[1];
            se = ~i[0];
            chan = 3'(i + 3);
            trim = 10'(12'h400 - 12'h100 * i);
            ntrim = trim;
            tick(2);
            check("attn", 16'(i), 16'(attn_o));
            check("bypass", {15'h0, i == 0}, {15'h0, bypass_o});
            check("mute", 16'(i % 2), {15'h0, mute_o});
            check("bias", 16'(i / 2), {15'h0, bias_o});
            check("single", 16'(1 - i % 2), {15'h0, se_o});
            check("chan", 16'(i + 3), 16'(chan_o));
            check("trim p", 16'(trim), 16'(ptrim_o));
            check("trim n", 16'(trim), 16'(ntrim_o));
        end
        start_wr = 1'b1;
        tick(1);
        start_wr = 1'b0;
        tick(3);
        check("refused", 16'h0, {15'h0, start_o});
        en = 1'b1;
        mute = 1'b1;
        se = 1'b1;
        smpl = 4'h2;
        avg = 3'h3;
        trim = TRIM_MID;
        ntrim = TRIM_MID;
        raw = 10'h205;
        convert(8, 16'h8140);
        res_p = result_o[15:6];
        check("sign 0", 16'h0, {15'h0, sign_hist[0]});
        sign = 1'b1;
        raw = 10'h1FB;
        convert(8, 16'h7EC0);
        res_n = result_o[15:6];
        check("sign 1", 16'h1, {15'h0, sign_hist[0]});
        sign = 1'b0;
        // Single-ended trims take twice the measured offset, differential ones take it once.
        trim = TRIM_MID - 10'h002 * (res_p - TRIM_MID);
        ntrim = TRIM_MID - 10'h002 * (res_n - TRIM_MID);
        tick(2);
        check("cal p se", 16'h01F6, 16'(ptrim_o));
        check("cal n se", 16'h020A, 16'(ntrim_o));
        raw = 10'h200;
        convert(8, 16'h8000);
        se = 1'b0;
        trim = TRIM_MID - (res_p - TRIM_MID);
        ntrim = TRIM_MID - (res_n - TRIM_MID);
        tick(2);
        check("cal p diff", 16'h01FB, 16'(ptrim_o));
        check("cal n diff", 16'h0205, 16'(ntrim_o));
        check("diff mode", 16'h0, {15'h0, se_o});
        trim = 10'h300;
        ntrim = 10'h300;
        tick(2);
        check("cm p", 16'h0300, 16'(ptrim_o));
        check("cm n", 16'h0300, 16'(ntrim_o));
        avg = 3'h2;
        raw = 10'h155;
        convert(4, 16'h5540);
        avg = 3'h0;
        chop = 1'b1;
        convert(2, 16'h5540);
        check("chop signs", 16'h1, 16'(sign_hist[1:0]));
        chop = 1'b0;
        avg = 3'h1;
        convert(2, 16'h5560, 2, 10'h156);
        // Continuous mode keeps start up across results until the mode is dropped.
        cont = 1'b1;
        start_wr = 1'b1;
        tick(1);
        start_wr = 1'b0;
        for (int k = 0; k < 3000 && irq_o !== 1'b1; k++) begin
            tick(1);
        end
        tick(2);
        check("cont busy", 16'h1, {15'h0, start_o});
        clr = 1'b1;
        cont = 1'b0;
        tick(1);
        clr = 1'b0;
        tick(1);
        check("cont clear", 16'h0, {15'h0, irq_o});
        for (int k = 0; k < 3000 && start_o === 1'b1; k++) begin
            tick(1);
        end
        check("cont stop", 16'h0, {15'h0, start_o});
        check("cont irq", 16'h1, {15'h0, irq_o});
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        // A frozen block must neither take a start nor follow its inputs.
        ce = 1'b0;
        mute = 1'b0;
        start_wr = 1'b1;
        tick(3);
        check("frozen start", 16'h0, {15'h0, start_o});
        check("frozen mute", 16'h1, {15'h0, mute_o});
        start_wr = 1'b0;
        ce = 1'b1;
        tick(2);
        check("thawed mute", 16'h0, {15'h0, mute_o});
        report_and_stop();
    end
endmodule
`default_nettype wire
